/* File: core/dbp_top.sv */
`timescale 1ns/1ps
module dbp_top (
    // Clock, reset, enable
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic        CE,
    // AXI4-Lite write address and data
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    // AXI4-Lite write response
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    output logic [1:0]       S_AXI_BRESP,
    // AXI4-Lite read
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    // Modulated pins
    output logic [1:0]       PWM_OUT,
    output logic [1:0]       PWM_OE
);

    logic       aw_held_q;
    logic [7:0] awaddr_q;
    logic       w_held_q;
    logic [7:0] wdata_q;
    logic       wstrb_q;
    logic       bvalid_q;
    logic [1:0] bresp_q;
    logic       rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic       aw_fire;
    logic       w_fire;
    logic       ar_fire;
    logic       wr_go;
    logic       wr_en;
    logic [7:0] wd;
    logic       w_tmr;
    logic       w_pr;
    logic       w_tbc;
    logic       w_dlow0;
    logic       w_dsh0;
    logic       w_cc0;
    logic       w_dlow1;
    logic       w_dsh1;
    logic       w_cc1;
    logic       w_dir;
    logic       w_stat;
    logic [7:0] rd_byte;

    // Write channels are taken independently and joined here
    assign S_AXI_AWREADY = CE && !aw_held_q && !bvalid_q;
    assign S_AXI_WREADY  = CE && !w_held_q && !bvalid_q;
    assign S_AXI_ARREADY = CE && !rvalid_q;
    // Gated so no handshake completes while state is frozen
    assign S_AXI_BVALID  = CE && bvalid_q;
    assign S_AXI_RVALID  = CE && rvalid_q;
    assign S_AXI_BRESP   = bresp_q;
    assign S_AXI_RDATA   = rdata_q;
    assign S_AXI_RRESP   = rresp_q;
    assign aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_fire  = S_AXI_WVALID && S_AXI_WREADY;
    assign ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;
    assign wr_go   = CE && aw_held_q && w_held_q && !bvalid_q;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= 8'h00;
        end else if (aw_fire) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= S_AXI_AWADDR;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            w_held_q <= 1'b0;
            wdata_q  <= 8'h00;
            wstrb_q  <= 1'b0;
        end else if (w_fire) begin
            w_held_q <= 1'b1;
            wdata_q  <= S_AXI_WDATA[7:0];
            wstrb_q  <= S_AXI_WSTRB[0];
        end else if (wr_go) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            bvalid_q <= 1'b0;
            bresp_q  <= dbp_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= dbp_pkg::reg_mapped(awaddr_q) ? dbp_pkg::RESP_OKAY
                                                      : dbp_pkg::RESP_SLVERR;
        end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // Byte lanes above the first carry nothing
    assign wr_en   = wr_go && wstrb_q;
    assign wd      = wdata_q;
    assign w_tmr   = wr_en && dbp_pkg::reg_hit(awaddr_q, dbp_pkg::OFS_TB_COUNT);
    assign w_pr    = wr_en && dbp_pkg::reg_hit(awaddr_q, dbp_pkg::OFS_PERIOD);
    assign w_tbc   = wr_en && dbp_pkg::reg_hit(awaddr_q, dbp_pkg::OFS_TB_CTRL);
    assign w_dlow0 = wr_en && dbp_pkg::reg_hit(awaddr_q, dbp_pkg::OFS_DLOW0);
    assign w_dsh0  = wr_en && dbp_pkg::reg_hit(awaddr_q, dbp_pkg::OFS_DSHAD0);
    assign w_cc0   = wr_en && dbp_pkg::reg_hit(awaddr_q, dbp_pkg::OFS_CCTRL0);
    assign w_dlow1 = wr_en && dbp_pkg::reg_hit(awaddr_q, dbp_pkg::OFS_DLOW1);
    assign w_dsh1  = wr_en && dbp_pkg::reg_hit(awaddr_q, dbp_pkg::OFS_DSHAD1);
    assign w_cc1   = wr_en && dbp_pkg::reg_hit(awaddr_q, dbp_pkg::OFS_CCTRL1);
    assign w_dir   = wr_en && dbp_pkg::reg_hit(awaddr_q, dbp_pkg::OFS_PIN_DIR);
    assign w_stat  = wr_en && dbp_pkg::reg_hit(awaddr_q, dbp_pkg::OFS_STATUS);

    // Software registers
    logic [7:0] tmr_q;
    logic [7:0] tmr_d;
    logic [7:0] pr_q;
    logic [6:0] tbc_q;
    logic [7:0] dlow0_q;
    logic [7:0] cc0_q;
    logic [7:0] dlow1_q;
    logic [5:0] cc1_q;
    logic [1:0] dir_q;
    logic       evt_q;
    logic       evt_d;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pr_q    <= dbp_pkg::RST_PERIOD;
            tbc_q   <= dbp_pkg::RST_TB_CTRL;
            dlow0_q <= dbp_pkg::RST_DLOW;
            cc0_q   <= dbp_pkg::RST_CCTRL;
            dlow1_q <= dbp_pkg::RST_DLOW;
            cc1_q   <= dbp_pkg::RST_CCTRL[5:0];
            dir_q   <= dbp_pkg::RST_PIN_DIR;
        end else begin
            if (w_pr)    pr_q    <= wd;
            if (w_tbc)   tbc_q   <= wd[6:0];
            if (w_dlow0) dlow0_q <= wd;
            if (w_cc0)   cc0_q   <= wd;
            if (w_dlow1) dlow1_q <= wd;
            if (w_cc1)   cc1_q   <= wd[5:0];
            if (w_dir)   dir_q   <= wd[1:0];
        end
    end

    // Timebase: quarter-cycle phase, prescaler, counter
    logic [1:0] q_q;
    logic [3:0] pre_q;
    logic [3:0] pre_d;
    logic [4:0] fac;
    logic       run;
    logic       pre_last;
    logic       inc;
    logic       restart;
    logic [9:0] fine;

    assign run      = tbc_q[dbp_pkg::TBC_RUN_BIT];
    assign fac      = dbp_pkg::pre_factor(tbc_q[dbp_pkg::TBC_PRE_LSB +: 2]);
    assign pre_last = {1'b0, pre_q} == fac - 5'h01;
    // One step per prescaled instruction cycle of four clocks
    assign inc      = CE && run && (q_q == 2'(dbp_pkg::OSC_PER_INSTR - 1)) && pre_last;
    assign restart  = inc && (tmr_q == pr_q) && !w_tmr;
    // A write to the count or control restarts the prescaler
    assign pre_d    = (w_tmr || w_tbc || inc) ? 4'h0 :
                      (run && q_q == 2'(dbp_pkg::OSC_PER_INSTR - 1)) ? pre_q + 4'h1 : pre_q;
    assign tmr_d    = w_tmr ? wd : restart ? 8'h00 : inc ? tmr_q + 8'h01 : tmr_q;
    assign fine     = {tmr_q, dbp_pkg::fine_sub(tbc_q[dbp_pkg::TBC_PRE_LSB +: 2], q_q, pre_q)};

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            q_q   <= 2'h0;
            pre_q <= 4'h0;
            tmr_q <= dbp_pkg::RST_TB_COUNT;
        end else if (CE) begin
            q_q   <= q_q + 2'h1;
            pre_q <= pre_d;
            tmr_q <= tmr_d;
        end
    end

    // Postscaler only paces the period event flag, never the pins
    logic [3:0] post_q;
    logic       post_hit;

    assign post_hit = post_q == tbc_q[dbp_pkg::TBC_POST_LSB +: 4];
    // A new event wins over a clear in the same cycle
    assign evt_d    = (restart && post_hit) || (evt_q && !(w_stat && wd[0]));

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            post_q <= 4'h0;
            evt_q  <= 1'b0;
        end else begin
            if (restart) post_q <= post_hit ? 4'h0 : post_q + 4'h1;
            evt_q <= evt_d;
        end
    end

    // Channels
    dbp_pkg::dbp_chan_cfg_t cfg0;
    dbp_pkg::dbp_chan_cfg_t cfg1;
    logic       pin0;
    logic       pin1;
    logic [7:0] shadow0;
    logic [7:0] shadow1;
    logic [9:0] dbuf0;
    logic [9:0] dbuf1;

    assign cfg0 = '{mode: cc0_q[dbp_pkg::CC_MODE_LSB +: 4],
                    duty: {dlow0_q, cc0_q[dbp_pkg::CC_DLSB_LSB +: 2]}};
    assign cfg1 = '{mode: cc1_q[dbp_pkg::CC_MODE_LSB +: 4],
                    duty: {dlow1_q, cc1_q[dbp_pkg::CC_DLSB_LSB +: 2]}};

    dbp_chan u_chan0 (
        .clk      (CLK),
        .rst_b    (RST_B),
        .ce       (CE),
        .restart  (restart),
        .fine     (fine),
        .cfg      (cfg0),
        .sh_wr    (w_dsh0),
        .sh_wdata (wd),
        .pin      (pin0),
        .shadow   (shadow0),
        .dbuf     (dbuf0)
    );

    dbp_chan u_chan1 (
        .clk      (CLK),
        .rst_b    (RST_B),
        .ce       (CE),
        .restart  (restart),
        .fine     (fine),
        .cfg      (cfg1),
        .sh_wr    (w_dsh1),
        .sh_wdata (wd),
        .pin      (pin1),
        .shadow   (shadow1),
        .dbuf     (dbuf1)
    );

    // Pins drive only when direction bits select output
    assign PWM_OUT = {pin1, pin0};
    assign PWM_OE  = ~dir_q;

    // Read selection; unused upper bits read as zero
    assign rd_byte =
        dbp_pkg::reg_hit(S_AXI_ARADDR, dbp_pkg::OFS_TB_COUNT) ? tmr_q :
        dbp_pkg::reg_hit(S_AXI_ARADDR, dbp_pkg::OFS_PERIOD)   ? pr_q :
        dbp_pkg::reg_hit(S_AXI_ARADDR, dbp_pkg::OFS_TB_CTRL)  ? {1'b0, tbc_q} :
        dbp_pkg::reg_hit(S_AXI_ARADDR, dbp_pkg::OFS_DLOW0)    ? dlow0_q :
        dbp_pkg::reg_hit(S_AXI_ARADDR, dbp_pkg::OFS_DSHAD0)   ? shadow0 :
        dbp_pkg::reg_hit(S_AXI_ARADDR, dbp_pkg::OFS_CCTRL0)   ? cc0_q :
        dbp_pkg::reg_hit(S_AXI_ARADDR, dbp_pkg::OFS_DLOW1)    ? dlow1_q :
        dbp_pkg::reg_hit(S_AXI_ARADDR, dbp_pkg::OFS_DSHAD1)   ? shadow1 :
        dbp_pkg::reg_hit(S_AXI_ARADDR, dbp_pkg::OFS_CCTRL1)   ? {2'h0, cc1_q} :
        dbp_pkg::reg_hit(S_AXI_ARADDR, dbp_pkg::OFS_PIN_DIR)  ? {6'h00, dir_q} :
        dbp_pkg::reg_hit(S_AXI_ARADDR, dbp_pkg::OFS_STATUS)   ? {7'h00, evt_q} : 8'h00;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= dbp_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_byte};
            rresp_q  <= dbp_pkg::reg_mapped(S_AXI_ARADDR) ? dbp_pkg::RESP_OKAY
                                                          : dbp_pkg::RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // Checking helpers: cycle counts since restart, only trusted
    // when nothing timing-related was rewritten in between
    logic        stable_q;
    logic [15:0] per_cnt_q;
    logic [15:0] hi_cnt_q;
    logic        pwm0;

    assign pwm0 = cc0_q[3:2] == dbp_pkg::MODE_PWM_HI;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            stable_q  <= 1'b0;
            per_cnt_q <= 16'h0000;
        end else begin
            if (w_tmr || w_pr || w_tbc || w_cc0) stable_q <= 1'b0;
            else if (restart) stable_q <= 1'b1;
            if (restart) per_cnt_q <= 16'h0000;
            else if (CE) per_cnt_q <= per_cnt_q + 16'h0001;
        end
    end

    assign hi_cnt_q = per_cnt_q;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    sequence new_period_s;
        restart && pwm0;
    endsequence

    period_len_a: assert property (restart && stable_q |->
        int'(per_cnt_q) == (int'(pr_q) + 1) * dbp_pkg::OSC_PER_INSTR * int'(fac) - 1)
        else $error("period length differs from programmed value");
    count_clear_a: assert property (CE && inc && tmr_q == pr_q && !w_tmr |=>
        tmr_q == 8'h00 && pre_q == 4'h0)
        else $error("count not cleared after limit match");
    pin_set_a: assert property (new_period_s ##1 (CE && pwm0) |=>
        pin0 == ($past(cfg0.duty, 2) != 10'h000))
        else $error("pin level wrong at period start");
    duty_latch_a: assert property (new_period_s |=> dbuf0 == $past(cfg0.duty))
        else $error("duty not latched at period start");
    high_time_a: assert property (CE && pwm0 && pin0 && !restart && stable_q
        && fine == dbuf0 |-> int'(hi_cnt_q) == int'(dbuf0) * int'(fac))
        else $error("high time differs from duty");
    duty_hold_a: assert property (CE && pwm0 && !restart && w_dlow0 |=> $stable(dbuf0))
        else $error("duty applied before period end");
    shadow_ro_a: assert property (CE && pwm0 && !restart && w_dsh0 |=> $stable(shadow0))
        else $error("shadow byte took a write");
    pin_clear_a: assert property (CE && pwm0 && pin0 && !restart && fine == dbuf0 |=> !pin0)
        else $error("pin not cleared on duty match");
    long_duty_a: assert property (CE && pwm0 && pin0 && !restart
        && dbuf0 > {pr_q, 2'h3} |=> pin0)
        else $error("pin cleared with duty beyond period");
    mode_off_a: assert property (CE && cc0_q[3:0] == dbp_pkg::MODE_OFF |=> !pin0
        && dbuf0[1:0] == 2'h0)
        else $error("channel not reset in off mode");
    pwm_sel_a: assert property ((restart && cfg1.mode[3:2] == dbp_pkg::MODE_PWM_HI
        && cfg1.duty != 10'h000) ##1 (CE && cfg1.mode[3:2] == dbp_pkg::MODE_PWM_HI) |=> pin1)
        else $error("second channel not modulating");
    ctrl_clear_a: assert property (w_cc0 && wd == 8'h00 |=>
        cc0_q == 8'h00 ##1 ($past(CE) -> !pin0))
        else $error("output latch not forced low");

endmodule // dbp_top

/* File: core/dbp_pkg.sv */
// Functional notes
// - Period is (limit+1) x 4 clocks x prescale.
// - Count equal to limit clears on next increment.
// - Restart drives pin high unless duty zero.
// - Restart copies written duty into shadow buffer.
// - Duty is low byte plus control bits 5:4.
// - High time is duty x clock x prescale.
// - Duty writes apply only after period completes.
// - Shadow byte read-only, ignores writes in PWM.
// - Shadow byte plus hidden 2-bit latch buffer duty.
// - Pin clears when duty equals extended count.
// - Duty beyond period keeps pin high all period.
// - Postscaler never affects PWM period or output.
// - Prescaler divides by one, four or sixteen.
// - Second channel has no automatic shutdown.
// - Mode 0000 turns channel off, clears pin and 2-bit latch.
// - Mode with upper bits 11 selects PWM.
// - Clearing channel control forces output latch low.
package dbp_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_TB_COUNT = 8'h00;
    localparam logic [7:0] OFS_PERIOD   = 8'h04;
    localparam logic [7:0] OFS_TB_CTRL  = 8'h08;
    localparam logic [7:0] OFS_DLOW0    = 8'h0c;
    localparam logic [7:0] OFS_DSHAD0   = 8'h10;
    localparam logic [7:0] OFS_CCTRL0   = 8'h14;
    localparam logic [7:0] OFS_DLOW1    = 8'h18;
    localparam logic [7:0] OFS_DSHAD1   = 8'h1c;
    localparam logic [7:0] OFS_CCTRL1   = 8'h20;
    localparam logic [7:0] OFS_PIN_DIR  = 8'h24;
    localparam logic [7:0] OFS_STATUS   = 8'h28;

    // Field positions
    localparam int TBC_PRE_LSB  = 0;
    localparam int TBC_RUN_BIT  = 2;
    localparam int TBC_POST_LSB = 3;
    localparam int CC_MODE_LSB  = 0;
    localparam int CC_DLSB_LSB  = 4;

    // Reset values
    localparam logic [7:0] RST_TB_COUNT = 8'h00;
    localparam logic [7:0] RST_PERIOD   = 8'hff;
    localparam logic [6:0] RST_TB_CTRL  = 7'h00;
    localparam logic [7:0] RST_DLOW     = 8'h00;
    localparam logic [7:0] RST_CCTRL    = 8'h00;
    localparam logic [1:0] RST_PIN_DIR  = 2'h3;

    // Timing counts: oscillator clocks per instruction, prescale factors
    localparam int OSC_PER_INSTR = 4;
    localparam int PRE_DIV1      = 1;
    localparam int PRE_DIV4      = 4;
    localparam int PRE_DIV16     = 16;

    // Modes and bus answers
    localparam logic [3:0] MODE_OFF    = 4'h0;
    localparam logic [1:0] MODE_PWM_HI = 2'h3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Channel settings as software last wrote them
    typedef struct packed {
        logic [3:0] mode;
        logic [9:0] duty;
    } dbp_chan_cfg_t;

    function automatic logic [4:0] pre_factor(input logic [1:0] sel);
        return (sel == 2'h0) ? 5'(PRE_DIV1) : (sel == 2'h1) ? 5'(PRE_DIV4) : 5'(PRE_DIV16);
    endfunction

    // Two sub-step bits that extend the count to ten bits
    function automatic logic [1:0] fine_sub(input logic [1:0] sel, input logic [1:0] q,
                                            input logic [3:0] pre);
        return (sel == 2'h0) ? q : (sel == 2'h1) ? pre[1:0] : pre[3:2];
    endfunction

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr[7:2] == ofs[7:2];
    endfunction

    function automatic logic reg_mapped(input logic [7:0] addr);
        return addr[7:2] <= OFS_STATUS[7:2];
    endfunction

endpackage

/* File: core/dbp_chan.sv */
`timescale 1ns/1ps
module dbp_chan (
    // Clock, reset, enable
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic                  ce,
    // Timebase
    input  wire logic                  restart,
    input  wire logic [9:0]            fine,
    // Software settings
    input  wire dbp_pkg::dbp_chan_cfg_t cfg,
    input  wire logic                  sh_wr,
    input  wire logic [7:0]            sh_wdata,
    // Outputs
    output logic                       pin,
    output logic [7:0]                 shadow,
    output logic [9:0]                 dbuf
);

    logic       pin_q;
    logic       pin_d;
    logic [7:0] shadow_q;
    logic [7:0] shadow_d;
    logic [1:0] lsb_q;
    logic [1:0] lsb_d;
    logic       pwm_on;
    logic       off;
    logic       start_q;
    logic       start_d;

    // Mode decode
    assign pwm_on = cfg.mode[3:2] == dbp_pkg::MODE_PWM_HI;
    assign off    = cfg.mode == dbp_pkg::MODE_OFF;

    // Pin rises one cycle after the latch, while the fine count reads zero,
    // so the high time is exactly duty steps; outside PWM it is held low
    assign start_d = pwm_on && restart;
    assign pin_d   = !pwm_on ? 1'b0 :
                     start_q ? (dbuf != 10'h000) :
                     (fine == dbuf) ? 1'b0 : pin_q;

    // Shadow loads only at the period boundary while modulating
    assign shadow_d = (pwm_on && restart) ? cfg.duty[9:2] :
                      (!pwm_on && sh_wr) ? sh_wdata : shadow_q;
    assign lsb_d    = off ? 2'h0 : (pwm_on && restart) ? cfg.duty[1:0] : lsb_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_q    <= 1'b0;
            shadow_q <= 8'h00;
            lsb_q    <= 2'h0;
            start_q  <= 1'b0;
        end else if (ce) begin
            pin_q    <= pin_d;
            shadow_q <= shadow_d;
            lsb_q    <= lsb_d;
            start_q  <= start_d;
        end
    end

    assign pin    = pin_q;
    assign shadow = shadow_q;
    assign dbuf   = {shadow_q, lsb_q};

endmodule // dbp_chan

/* File: tb/dbp_top_tb.sv */
`timescale 1ns/1ps
module dbp_top_tb;
    // Bench-side copies of the ports
    logic        clk, rst_b, ce;
    logic        aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
    logic [7:0]  aw_a, ar_a;
    logic [31:0] w_d, r_d;
    logic [3:0]  w_s;
    logic [1:0]  b_resp, r_resp, pwm_out, pwm_oe;
    // Expectation queues and counters
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    logic [19:0] pq[$];
    int          err_count, tests_run, hcnt, pcnt;
    int          cyc = 0;
    logic        prev_pin;
    logic [31:0] seed;
    localparam logic [1:0] OK  = dbp_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = dbp_pkg::RESP_SLVERR;

    dbp_top DUT (
        .CLK(clk), .RST_B(rst_b), .CE(ce),
        .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_r), .S_AXI_AWADDR(aw_a),
        .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_r), .S_AXI_WDATA(w_d), .S_AXI_WSTRB(w_s),
        .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r), .S_AXI_BRESP(b_resp),
        .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_r), .S_AXI_ARADDR(ar_a),
        .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r), .S_AXI_RDATA(r_d), .S_AXI_RRESP(r_resp),
        .PWM_OUT(pwm_out), .PWM_OE(pwm_oe)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic fail(input string m);
        err_count++;
        $display("[FAIL] %0t %s", $time, m);
    endtask

    task automatic summarize;
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Ceiling well above the longest prescale-16 measurement
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail("timeout");
            summarize;
        end
    end

    // Bus answers, sampled mid-cycle where they are settled
    always @(negedge clk) begin
        if (b_v && b_r) begin
            tests_run++;
            if (bq.size() == 0 || b_resp !== bq.pop_front()) fail("write response");
        end
        if (r_v && r_r) begin
            tests_run++;
            if (rq.size() == 0 || {r_resp, r_d} !== rq.pop_front()) fail("read data");
        end
    end

    // First channel pulse, measured rise to rise; only checked while notes wait
    always @(negedge clk) begin
        if (pwm_out[0] === 1'b1 && prev_pin === 1'b0) begin
            if (pq.size() > 0) begin
                tests_run++;
                if ({hcnt[9:0], pcnt[9:0]} !== pq.pop_front()) fail("pulse shape");
            end
            hcnt = 1;
            pcnt = 1;
        end else begin
            pcnt++;
            if (pwm_out[0] === 1'b1) hcnt++;
        end
        prev_pin = pwm_out[0];
    end

    // Ready is sampled mid-cycle, so release lands right after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw, w, b;
        bq.push_back(er);
        aw_a <= a;
        w_d <= {24'h0, d};
        aw_v <= 1'b1;
        w_v <= 1'b1;
        do begin
            @(negedge clk);
            aw = aw_v && aw_r;
            w = w_v && w_r;
            b = b_v && b_r;
            @(posedge clk);
            if (aw) aw_v <= 1'b0;
            if (w) w_v <= 1'b0;
        end while (!b);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ar, r;
        rq.push_back({er, 24'h0, d});
        ar_a <= a;
        ar_v <= 1'b1;
        do begin
            @(negedge clk);
            ar = ar_v && ar_r;
            r = r_v && r_r;
            @(posedge clk);
            if (ar) ar_v <= 1'b0;
        end while (!r);
    endtask

    // Count cleared first so a shorter limit never leaves it stranded above
    task automatic setup(input logic [1:0] pre, input logic [3:0] post, input logic [7:0] pl,
                         input logic [9:0] duty);
        wr(dbp_pkg::OFS_TB_COUNT, 8'h00, OK);
        wr(dbp_pkg::OFS_PERIOD, pl, OK);
        wr(dbp_pkg::OFS_DLOW0, duty[9:2], OK);
        wr(dbp_pkg::OFS_TB_CTRL, {1'b0, post, 1'b1, pre}, OK);
        wr(dbp_pkg::OFS_CCTRL0, {2'b00, duty[1:0], 2'b11, pre}, OK);
    endtask

    // Settle three periods, then expect two identical pulses
    task automatic meas(input int h, input int p);
        repeat (3 * p) @(posedge clk);
        pq.push_back({h[9:0], p[9:0]});
        pq.push_back({h[9:0], p[9:0]});
        repeat (3 * p) @(posedge clk);
        if (pq.size() != 0) fail("missing pulses");
        pq.delete();
    endtask

    task automatic hold(input logic v, input int n);
        repeat (n) begin
            @(negedge clk);
            tests_run++;
            if (pwm_out[0] !== v) fail("pin level");
        end
        @(posedge clk);
    endtask

    initial begin
        logic [9:0] d;
        int         f;
        logic [1:0] frz;
        int         cnt;
        rst_b = 1'b0;
        ce = 1'b1;
        aw_v = 1'b0;
        w_v = 1'b0;
        ar_v = 1'b0;
        b_r = 1'b1;
        r_r = 1'b1;
        aw_a = 8'h00;
        ar_a = 8'h00;
        w_d = 32'h0;
        w_s = 4'h1;
        prev_pin = 1'b0;
        seed = 32'hca88;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        // Reset values, unmapped place, disabled byte lane
        rd(dbp_pkg::OFS_PERIOD, 8'hff, OK);
        rd(dbp_pkg::OFS_PIN_DIR, 8'h03, OK);
        rd(dbp_pkg::OFS_TB_CTRL, 8'h00, OK);
        rd(8'h2c, 8'h00, ERR);
        wr(8'h2c, 8'h5a, ERR);
        w_s <= 4'h0;
        wr(dbp_pkg::OFS_PERIOD, 8'h55, OK);
        w_s <= 4'h1;
        rd(dbp_pkg::OFS_PERIOD, 8'hff, OK);
        wr(dbp_pkg::OFS_PIN_DIR, 8'h00, OK);
        @(negedge clk);
        tests_run++;
        if (pwm_oe !== 2'b11) fail("output enable");
        @(posedge clk);
        // Every prescale factor, random duty inside a 32-cycle base period
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            d = 10'(seed % 31) + 10'd1;
            f = (i == 0) ? 1 : (i == 1) ? 4 : 16;
            setup(2'(i), 4'(i * 5), 8'h07, d);
            meas(int'(d) * f, 32 * f);
        end
        // Shadow byte follows the latched duty and ignores writes
        rd(dbp_pkg::OFS_DSHAD0, d[9:2], OK);
        wr(dbp_pkg::OFS_DSHAD0, ~d[9:2], OK);
        rd(dbp_pkg::OFS_DSHAD0, d[9:2], OK);
        setup(2'd0, 4'd0, 8'h01, 10'd20);
        repeat (24) @(posedge clk);
        hold(1'b1, 40);
        wr(dbp_pkg::OFS_DLOW0, 8'h00, OK);
        wr(dbp_pkg::OFS_CCTRL0, 8'h0c, OK);
        repeat (24) @(posedge clk);
        hold(1'b0, 40);
        setup(2'd0, 4'd0, 8'h01, 10'd4);
        meas(4, 8);
        wr(dbp_pkg::OFS_CCTRL0, 8'h00, OK);
        repeat (2) @(posedge clk);
        hold(1'b0, 40);
        wr(dbp_pkg::OFS_CCTRL1, 8'hff, OK);
        rd(dbp_pkg::OFS_CCTRL1, 8'h3f, OK);
        // Second pin: duty 3 in an 8-cycle period, so any 8 cycles hold 3 high
        repeat (24) @(posedge clk);
        cnt = 0;
        repeat (8) begin
            @(negedge clk);
            if (pwm_out[1] === 1'b1) cnt++;
        end
        tests_run++;
        if (cnt != 3) fail("second pin duty");
        // Enable low freezes both pins wherever they stood
        @(posedge clk);
        ce <= 1'b0;
        @(negedge clk);
        frz = pwm_out;
        repeat (20) begin
            @(negedge clk);
            tests_run++;
            if (pwm_out !== frz) fail("pins moved while frozen");
        end
        @(posedge clk);
        ce <= 1'b1;
        summarize;
    end
endmodule // dbp_top_tb
